/* logic/can_power_timing.v */
// can controller power modes, wake-up, frame timer link and bit timing
// assumes one 40 mhz clock; stop_mode and can_receive_pin are synchronous;
// frame_valid_eof comes from the protocol engine at end of every good frame
`timescale 1ns/1ps
`include "can_pm_map.vh"

// Overview of operation
// - sleep request clear ignored until acknowledged
// - eleven recessive bits after any wake-up
// - receive buffers held through sleep
// - deferred copy, abort, transmit on wake
// - bus-off recovery count resumes after sleep
// - soft reset halts engine, registers stay
// - soft reset aborts frames at once
// - cpu stop forces power-down, aborts frames
// - transmit pin recessive in power-down
// - no register access in power-down
// - bus wakes mcu, data ignored until synced
// - wait mode keeps controller fully active
// - optional glitch filter on sleep wake-up
// - one bit-time pulse after valid frame
// - timer pulse gated by link enable
// - clock select picks crystal or pll
// - prescaler makes time-quantum enable
// - sync segment is one quantum
// - first segment four to sixteen quanta
// - second segment two to eight quanta
// - jump width one to four quanta
// - fields hold length minus one
// - sample at point, one sample per bit
// - acknowledge in sleep, two wake causes
module can_power_timing #(
  parameter DATA_W = 32
) (
  input wire clk,                        // 40 mhz system clock
  input wire srst,                       // synchronous reset, active high
  input wire xtal_tick,                  // crystal clock enable pulse
  input wire pll_tick,                   // pll clock enable pulse
  input wire stop_mode,                  // cpu in stop mode
  input wire wait_mode,                  // cpu in wait mode
  input wire can_receive_pin,            // can rx line, 1 is recessive
  input wire frame_valid_eof,            // valid frame end-of-frame seen
  input wire engine_busy,                // protocol engine inside a frame
  input wire busoff_state,               // engine reports bus-off
  input wire engine_irq,                 // enabled engine interrupt
  input wire [11:0] s_axi_awaddr,        // write address
  input wire s_axi_awvalid,              // write address valid
  output reg s_axi_awready,              // write address ready
  input wire [DATA_W-1:0] s_axi_wdata,   // write data
  input wire [3:0] s_axi_wstrb,          // write byte strobes
  input wire s_axi_wvalid,               // write data valid
  output reg s_axi_wready,               // write data ready
  output reg [1:0] s_axi_bresp,          // write response
  output reg s_axi_bvalid,               // write response valid
  input wire s_axi_bready,               // write response ready
  input wire [11:0] s_axi_araddr,        // read address
  input wire s_axi_arvalid,              // read address valid
  output reg s_axi_arready,              // read address ready
  output reg [DATA_W-1:0] s_axi_rdata,   // read data
  output reg [1:0] s_axi_rresp,          // read response
  output reg s_axi_rvalid,               // read data valid
  input wire s_axi_rready,               // read data ready
  output reg can_transmit_pin,           // can tx line
  output reg timer_capture_in,           // frame pulse to timer channel
  output reg tq_tick,                    // time-quantum enable
  output reg sample_tick,                // sample point enable
  output reg engine_enable,              // engine may take part on bus
  output reg engine_abort,               // abort frame in progress
  output reg tx_start,                   // deferred transmission start
  output reg mcu_wakeup,                 // wake request to mcu
  output reg cpu_wake_irq                // wait mode exit request
);

  // one-hot mode states
  localparam [4:0] ST_NORMAL = 5'h01;
  localparam [4:0] ST_SLEEP = 5'h02;
  localparam [4:0] ST_SOFT = 5'h04;
  localparam [4:0] ST_PDOWN = 5'h08;
  localparam [4:0] ST_SYNC = 5'h10;

  reg [4:0] mode_reg;
  reg [4:0] mode_next;
  reg [31:0] ctrl_reg;
  reg [31:0] timing_reg;
  reg [31:0] receive_foreground_buffer_reg;
  reg [31:0] receive_background_buffer_reg;
  reg [31:0] txdata_reg;
  reg rxf_reg;
  reg receive_background_buffer_full_reg;
  reg tx_pend_reg;
  reg abort_pend_reg;
  reg [3:0] rec_cnt_reg;
  reg [6:0] group_cnt_reg;
  reg [7:0] filt_cnt_reg;
  reg [5:0] presc_cnt_reg;
  reg [4:0] tq_cnt_reg;
  reg pulse_pend_reg;
  reg pulse_reg;
  reg rx_prev_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  wire in_sleep = mode_reg[1];
  wire in_soft = mode_reg[2];
  wire in_pdown = mode_reg[3];
  wire in_sync = mode_reg[4];

  // merge strobed bytes of a write into a register value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // decode whether an offset names a mapped register
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_CTRL) || (a == `OFS_TIMING) || (a == `OFS_STATUS) ||
               (a == `OFS_RECEIVE_FOREGROUND_BUFFER) || (a == `OFS_TXDATA) || (a == `OFS_CMD) ||
               (a == `OFS_RECEIVE_BACKGROUND_BUFFER);
    end
  endfunction

  // bit timing fields
  // fields minus one
  wire [5:0] presc_f = timing_reg[`TIM_PRESC_MSB:`TIM_PRESC_LSB];
  wire [3:0] seg1_raw = timing_reg[`TIM_SEG1_MSB:`TIM_SEG1_LSB];
  wire [2:0] seg2_raw = timing_reg[`TIM_SEG2_MSB:`TIM_SEG2_LSB];
  wire [3:0] seg1_f = (seg1_raw < `SEG1_MIN) ? `SEG1_MIN : seg1_raw;
  wire [2:0] seg2_f = (seg2_raw < `SEG2_MIN) ? `SEG2_MIN : seg2_raw;
  wire [1:0] sjw_f = timing_reg[`TIM_SJW_MSB:`TIM_SJW_LSB];
  wire [4:0] bit_last = {1'b0, seg1_f} + {2'b00, seg2_f} + 5'h02;
  wire [4:0] samp_q = {1'b0, seg1_f} + 5'h01;
  wire src_tick = ctrl_reg[`CTRL_CLKSEL] ? pll_tick : xtal_tick;
  wire clk_run = !in_sleep && !in_soft && !in_pdown;
  wire rx_edge = rx_prev_reg && !can_receive_pin;
  // first quantum of a new bit, the sync quantum
  wire bit_start = tq_tick && (tq_cnt_reg == 5'h00);

  // wake-up detect, optionally glitch filtered
  // low-pass wake filter
  wire wake_bus = ctrl_reg[`CTRL_WUFILT] ? (filt_cnt_reg == `WAKE_FILTER_CYC)
                                           : !can_receive_pin;

  // write channel handshakes
  wire w_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  // power-down counts from the cycle stop is seen, so no access slips in
  wire pd_now = in_pdown || stop_mode;
  wire w_ok = w_go && !pd_now && mapped(awaddr_reg);
  wire ctrl_wr = w_ok && (awaddr_reg == `OFS_CTRL);
  wire [31:0] ctrl_new = merge(ctrl_reg, wdata_reg, wstrb_reg);
  wire cmd_wr = w_ok && (awaddr_reg == `OFS_CMD);
  // a load in the same cycle wins, so the flag never runs ahead of the copy
  wire copy_go = clk_run && !in_sync && receive_background_buffer_full_reg && !rxf_reg &&
                 !(cmd_wr && wdata_reg[`CMD_RECEIVE_BACKGROUND_BUFFER_LOAD]);
  wire slp_clr = ctrl_wr && !ctrl_new[`CTRL_SLEEP_REQUEST];
  wire soft_set = ctrl_wr && ctrl_new[`CTRL_SOFTRST];

  // mode state machine
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_NORMAL: begin
        if (stop_mode) begin
          mode_next = ST_PDOWN;
        end else if (ctrl_reg[`CTRL_SOFTRST]) begin
          mode_next = ST_SOFT;
        end else if (ctrl_reg[`CTRL_SLEEP_REQUEST] && !engine_busy && !tx_pend_reg) begin
          mode_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (stop_mode) begin
          mode_next = ST_PDOWN;
        end else if (soft_set) begin
          mode_next = ST_SOFT;
        end else if (slp_clr || wake_bus) begin
          mode_next = ST_SYNC;
        end
      end
      ST_SOFT: begin
        if (stop_mode) begin
          mode_next = ST_PDOWN;
        end else if (!ctrl_reg[`CTRL_SOFTRST]) begin
          mode_next = ST_SYNC;
        end
      end
      ST_PDOWN: begin
        if (!stop_mode) begin
          mode_next = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (stop_mode) begin
          mode_next = ST_PDOWN;
        end else if (ctrl_reg[`CTRL_SOFTRST]) begin
          mode_next = ST_SOFT;
        end else if (sample_tick && can_receive_pin && rec_cnt_reg == `RECESSIVE_RUN) begin
          mode_next = ST_NORMAL;
        end
      end
      default: begin
        mode_next = ST_SOFT;
      end
    endcase
  end

  // mode, control and buffer registers
  always @(posedge clk) begin
    if (srst) begin
      mode_reg <= ST_SOFT;
      ctrl_reg <= `CTRL_RESET;
      timing_reg <= `TIMING_RESET;
      receive_foreground_buffer_reg <= 32'h0000_0000;
      receive_background_buffer_reg <= 32'h0000_0000;
      txdata_reg <= 32'h0000_0000;
      rxf_reg <= 1'b0;
      receive_background_buffer_full_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      abort_pend_reg <= 1'b0;
      filt_cnt_reg <= 8'h00;
      rx_prev_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      rx_prev_reg <= can_receive_pin;
      // glitch filter counts low samples while asleep
      if (in_sleep && !can_receive_pin) begin
        if (filt_cnt_reg != `WAKE_FILTER_CYC) begin
          filt_cnt_reg <= filt_cnt_reg + 8'h01;
        end
      end else begin
        filt_cnt_reg <= 8'h00;
      end
      if (ctrl_wr) begin
        ctrl_reg <= {ctrl_new[31:1], ctrl_new[`CTRL_SLEEP_REQUEST] | (ctrl_reg[`CTRL_SLEEP_REQUEST] & !in_sleep)};
      end
      // timing writable only in soft reset
      if (w_ok && awaddr_reg == `OFS_TIMING && in_soft) begin
        timing_reg <= merge(timing_reg, wdata_reg, wstrb_reg);
      end
      if (w_ok && awaddr_reg == `OFS_TXDATA) begin
        txdata_reg <= merge(txdata_reg, wdata_reg, wstrb_reg);
      end
      if (cmd_wr && wdata_reg[`CMD_RECEIVE_BACKGROUND_BUFFER_LOAD]) begin
        receive_background_buffer_reg <= txdata_reg;
        receive_background_buffer_full_reg <= 1'b1;
      end else if (copy_go) begin
        receive_foreground_buffer_reg <= receive_background_buffer_reg;
        receive_background_buffer_full_reg <= 1'b0;
      end
      if (copy_go) begin
        rxf_reg <= 1'b1;
      end else if (cmd_wr && wdata_reg[`CMD_RXCLR]) begin
        rxf_reg <= 1'b0;
      end
      if (cmd_wr && wdata_reg[`CMD_TXREQ]) begin
        tx_pend_reg <= 1'b1;
      end else if (mode_reg == ST_NORMAL) begin
        tx_pend_reg <= 1'b0;
      end
      if (cmd_wr && wdata_reg[`CMD_ABORT]) begin
        abort_pend_reg <= 1'b1;
      end else if (mode_reg == ST_NORMAL) begin
        abort_pend_reg <= 1'b0;
      end
    end
  end

  // prescaler and bit-time sequencing
  always @(posedge clk) begin
    if (srst) begin
      presc_cnt_reg <= 6'h00;
      tq_cnt_reg <= 5'h00;
      pulse_pend_reg <= 1'b0;
      tq_tick <= 1'b0;
      sample_tick <= 1'b0;
      rec_cnt_reg <= 4'h0;
      group_cnt_reg <= 7'h00;
      pulse_reg <= 1'b0;
    end else begin
      tq_tick <= 1'b0;
      sample_tick <= 1'b0;
      if (clk_run && src_tick) begin
        if (presc_cnt_reg >= presc_f) begin
          presc_cnt_reg <= 6'h00;
          tq_tick <= 1'b1;
          if (rx_edge && tq_cnt_reg != 5'h00 && tq_cnt_reg <= {3'b000, sjw_f} + 5'h01) begin
            tq_cnt_reg <= 5'h01;
          end else if (tq_cnt_reg >= bit_last) begin
            tq_cnt_reg <= 5'h00;
          end else begin
            tq_cnt_reg <= tq_cnt_reg + 5'h01;
          end
          if (tq_cnt_reg == samp_q) begin
            sample_tick <= 1'b1;
          end
        end else begin
          presc_cnt_reg <= presc_cnt_reg + 6'h01;
        end
      end
      if (sample_tick) begin
        if (!can_receive_pin) begin
          rec_cnt_reg <= 4'h0;
        end else if (rec_cnt_reg == `RECESSIVE_RUN) begin
          rec_cnt_reg <= 4'h0;
          if (busoff_state && group_cnt_reg != `BUSOFF_GROUPS) begin
            group_cnt_reg <= group_cnt_reg + 7'h01;
          end
        end else begin
          rec_cnt_reg <= rec_cnt_reg + 4'h1;
        end
      end
      if (!busoff_state) begin
        group_cnt_reg <= 7'h00;
      end
      // fresh run count on every wake-up
      if (!in_sync && mode_next == ST_SYNC) begin
        rec_cnt_reg <= 4'h0;
      end
      // pulse spans the next whole bit; a frame end wins over clear
      if (frame_valid_eof && clk_run) begin
        pulse_pend_reg <= 1'b1;
      end else if (bit_start) begin
        pulse_pend_reg <= 1'b0;
      end
      if (bit_start) begin
        pulse_reg <= pulse_pend_reg;
      end
    end
  end

  // pin and engine outputs
  always @(posedge clk) begin
    if (srst) begin
      can_transmit_pin <= 1'b1;
      timer_capture_in <= 1'b0;
      engine_enable <= 1'b0;
      engine_abort <= 1'b0;
      tx_start <= 1'b0;
      mcu_wakeup <= 1'b0;
      cpu_wake_irq <= 1'b0;
    end else begin
      can_transmit_pin <= 1'b1;
      timer_capture_in <= pulse_reg && ctrl_reg[`CTRL_TLINK];
      engine_enable <= (mode_reg == ST_NORMAL) && !stop_mode; // drops with stop at once
      engine_abort <= (soft_set && engine_busy) || (stop_mode && !in_pdown) ||
                      (mode_reg == ST_NORMAL && abort_pend_reg);
      tx_start <= (mode_reg == ST_NORMAL) && !stop_mode && tx_pend_reg;
      mcu_wakeup <= in_pdown && stop_mode && !can_receive_pin;
      cpu_wake_irq <= wait_mode && engine_irq && (mode_reg == ST_NORMAL);
    end
  end

  // axi4-lite slave
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `AXI_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_reg && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_hold_reg && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (w_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (pd_now || !mapped(s_axi_araddr)) ? `AXI_SLVERR : `AXI_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (!pd_now) begin
          case (s_axi_araddr)
            `OFS_CTRL: s_axi_rdata <= ctrl_reg;
            `OFS_TIMING: s_axi_rdata <= timing_reg;
            `OFS_STATUS: begin
              s_axi_rdata <= {26'h0, tx_pend_reg, rxf_reg, busoff_state,
                              mode_reg == ST_NORMAL, 1'b0, in_sleep};
            end
            `OFS_RECEIVE_FOREGROUND_BUFFER: s_axi_rdata <= receive_foreground_buffer_reg;
            `OFS_TXDATA: s_axi_rdata <= txdata_reg;
            `OFS_RECEIVE_BACKGROUND_BUFFER: s_axi_rdata <= receive_background_buffer_reg;
            default: s_axi_rdata <= 32'h0000_0000;
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* logic/can_pm_map.vh */
// register offsets, field positions, reset values and timing constants
// for the can power-mode and bit-timing block; definitions only
`ifndef CAN_PM_MAP_VH
`define CAN_PM_MAP_VH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_TIMING 12'h004
`define OFS_STATUS 12'h008
`define OFS_RECEIVE_FOREGROUND_BUFFER 12'h00c
`define OFS_TXDATA 12'h010
`define OFS_CMD 12'h014
`define OFS_RECEIVE_BACKGROUND_BUFFER 12'h018

// control register fields
`define CTRL_SLEEP_REQUEST 0
`define CTRL_SOFTRST 1
`define CTRL_WUFILT 2
`define CTRL_TLINK 3
`define CTRL_CLKSEL 4
`define CTRL_RESET 32'h0000_0002

// timing register fields
`define TIM_PRESC_LSB 0
`define TIM_PRESC_MSB 5
`define TIM_SEG1_LSB 8
`define TIM_SEG1_MSB 11
`define TIM_SEG2_LSB 12
`define TIM_SEG2_MSB 14
`define TIM_SJW_LSB 16
`define TIM_SJW_MSB 17
`define TIM_SAMP3 20
`define TIMING_RESET 32'h0001_3503

// status register fields
`define ST_SLEEP_ACKNOWLEDGE 0
`define ST_PDOWN 1
`define ST_ONLINE 2
`define ST_BUSOFF 3
`define ST_RXF 4
`define ST_TXPEND 5

// command register fields
`define CMD_TXREQ 0
`define CMD_ABORT 1
`define CMD_RXCLR 2
`define CMD_RECEIVE_BACKGROUND_BUFFER_LOAD 3

// field limits
`define SEG1_MIN 4'h3
`define SEG2_MIN 3'h1

// bus protocol values
`define RECESSIVE_RUN 4'ha
`define BUSOFF_GROUPS 7'h7f
`define WAKE_FILTER_CYC 8'h3f
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

/* dv/can_power_timing_properties.sv */
// port-level assertions for the can power-mode and bit-timing block
// assumes one clock and a synchronous active-high reset; attached by bind
`timescale 1ns/1ps
`include "can_pm_map.vh"
module can_pm_props #(
  parameter DATA_W = 32
) (
  input wire clk,                      // system clock
  input wire srst,                     // reset
  input wire stop_mode,                // cpu stop
  input wire wait_mode,                // cpu wait
  input wire engine_busy,              // frame in progress
  input wire engine_irq,               // engine interrupt
  input wire s_axi_arvalid,            // read address valid
  input wire s_axi_arready,            // read address ready
  input wire [DATA_W-1:0] s_axi_rdata, // read data
  input wire [1:0] s_axi_rresp,        // read response
  input wire s_axi_rvalid,             // read valid
  input wire s_axi_rready,             // read ready
  input wire can_transmit_pin,         // tx line
  input wire engine_enable,            // engine on bus
  input wire engine_abort,             // frame abort
  input wire tx_start,                 // transmit start
  input wire mcu_wakeup,               // wake to mcu
  input wire cpu_wake_irq,             // wait exit
  input wire timer_capture_in          // frame pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_tx_recessive: assert property (can_transmit_pin)
    else $error("tx pin left recessive level");
  chk_wake_cause: assert property (cpu_wake_irq |-> $past(wait_mode) && $past(engine_irq))
    else $error("wait exit without wait and interrupt");
  chk_wait_active: assert property (wait_mode && engine_irq ##1 engine_enable |-> cpu_wake_irq)
    else $error("interrupt in wait mode not passed on");
  chk_stop_halts: assert property (stop_mode |=> !engine_enable && !tx_start)
    else $error("engine still running in power-down");
  chk_stop_abort: assert property ($rose(stop_mode) && engine_busy |-> ##[0:2] engine_abort)
    else $error("stop entry did not abort frame");
  chk_pd_read_err: assert property (stop_mode && s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rresp == `AXI_SLVERR && s_axi_rdata == '0)
    else $error("register answered in power-down");
  chk_wake_source: assert property (mcu_wakeup |-> $past(stop_mode))
    else $error("mcu wake outside power-down");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before ready");

  cov_abort: cover property (engine_abort);
  cov_timer: cover property ($rose(timer_capture_in));
  cov_wait: cover property (cpu_wake_irq);
endmodule

/* dv/can_bus_model.sv */
// far side: clock-source enables and the can bus level seen by the block
// assumes the bench asks for a dominant bus through rx_dom
`timescale 1ns/1ps
module can_bus_model (
  input wire clk,                   // system clock
  input wire srst,                  // reset
  input wire rx_dom,                // bench wants dominant bus
  output reg xtal_tick = 1'b0,      // crystal enable, every 2 cycles
  output reg pll_tick = 1'b0,       // pll enable, every 3 cycles
  output reg can_receive_pin = 1'b1 // bus level, 1 is recessive
);
  reg [1:0] div_reg = 2'h0;
  // two sources at distinct rates so the selection shows
  always @(posedge clk) begin
    if (srst) begin
      div_reg <= 2'h0;
      xtal_tick <= 1'b0;
      pll_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      xtal_tick <= ~xtal_tick;
      pll_tick <= (div_reg == 2'h2);
    end
  end
  // bus idles recessive, dominant only on request
  always @(posedge clk) begin
    can_receive_pin <= ~rx_dom;
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the can power-mode and bit-timing block
// assumes the bus model supplies clock enables and the rx line
`timescale 1ns/1ps
`include "can_pm_map.vh"
`define CHK(a, e) begin cmp_count = cmp_count + 1; if ((a) !== (e)) begin \
  fails = fails + 1; $display("mismatch %0t got %0h want %0h", $time, a, e); end end
module testbench;
  localparam BIT_CYC = 42; // pll enable every 3, prescale 2, 7 quanta
  reg clk = 1'b0, srst = 1'b1, stop_mode = 1'b0, wait_mode = 1'b0, rx_dom = 1'b0;
  reg frame_valid_eof = 1'b0, engine_busy = 1'b0, busoff_state = 1'b0, engine_irq = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg [31:0] s_axi_wdata = 32'h0, d;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire xtal_tick, pll_tick, can_receive_pin, can_transmit_pin, timer_capture_in;
  wire tq_tick, sample_tick, engine_enable, engine_abort, tx_start, mcu_wakeup, cpu_wake_irq;
  integer fails = 0, cmp_count = 0, n, h;

  can_bus_model bus (.*);
  can_power_timing #(.DATA_W(32)) uut (.*);

  initial forever #12.5 clk = ~clk;

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      fails = fails + 1;
      give_verdict;
    end
  endtask
  // axi4-lite write, address and data offered together
  task wr(input [11:0] a, input [31:0] v);
    reg got;
    integer i;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      got = 1'b0;
      for (i = 0; i < 50 && !got; i = i + 1) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          got = 1'b1;
          s_axi_bready <= 1'b0;
        end
      end
      if (!got) tmo;
    end
  endtask
  // axi4-lite read into d and r
  task rd(input [11:0] a);
    reg got;
    integer i;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      got = 1'b0;
      for (i = 0; i < 50 && !got; i = i + 1) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          got = 1'b1;
          s_axi_rready <= 1'b0;
        end
      end
      if (!got) tmo;
    end
  endtask
  function pick(input [2:0] s);
    case (s)
      3'h0: pick = engine_enable;
      3'h1: pick = timer_capture_in;
      3'h2: pick = mcu_wakeup;
      3'h3: pick = cpu_wake_irq;
      3'h4: pick = engine_abort;
      3'h5: pick = tq_tick;
      default: pick = sample_tick;
    endcase
  endfunction
  // bounded wait for a chosen output, cycles in n
  task wait_for(input [2:0] s, input integer lim);
    begin
      n = 0;
      while (pick(s) !== 1'b1 && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= lim) tmo;
    end
  endtask
  task count_high(input [2:0] s, input integer c);
    integer i;
    begin
      h = 0;
      for (i = 0; i < c; i = i + 1) begin
        @(posedge clk);
        if (pick(s) === 1'b1) h = h + 1;
      end
    end
  endtask
  task period(input [2:0] s);
    begin
      wait_for(s, 500);
      @(posedge clk);
      wait_for(s, 500);
      n = n + 1;
    end
  endtask
  task go_normal(input [31:0] v);
    begin
      wr(`OFS_CTRL, v);
      wait_for(3'h0, 3000);
    end
  endtask
  task poll_ack(input e);
    integer i;
    begin
      rd(`OFS_STATUS);
      for (i = 0; i < 200 && d[`ST_SLEEP_ACKNOWLEDGE] !== e; i = i + 1)
        rd(`OFS_STATUS);
    end
  endtask
  task pulse_eof;
    begin
      @(posedge clk);
      frame_valid_eof <= 1'b1;
      @(posedge clk);
      frame_valid_eof <= 1'b0;
    end
  endtask

  task t_regs;
    begin
      rd(`OFS_CTRL);
      `CHK(d, `CTRL_RESET)
      rd(`OFS_TIMING);
      `CHK(d, `TIMING_RESET)
      rd(12'h020);
      `CHK(r, `AXI_SLVERR)
    end
  endtask
  // prescale 2, first segment 4, second segment 2, pll source
  task t_timing;
    begin
      wr(`OFS_TIMING, 32'h0000_1301);
      rd(`OFS_TIMING);
      `CHK(d, 32'h0000_1301)
      wr(`OFS_CTRL, 32'h12);
      go_normal(32'h10);
      period(3'h5);
      `CHK(n, 6)
      period(3'h6);
      `CHK(n, BIT_CYC)
      wr(`OFS_TIMING, `TIMING_RESET);
      rd(`OFS_TIMING);
      `CHK(d, 32'h0000_1301)
    end
  endtask
  task t_sleep;
    begin
      @(posedge clk);
      engine_busy <= 1'b1;
      wr(`OFS_CTRL, 32'h11);
      wr(`OFS_CTRL, 32'h10);
      rd(`OFS_CTRL);
      `CHK(d[`CTRL_SLEEP_REQUEST], 1'b1)
      @(posedge clk);
      engine_busy <= 1'b0;
      poll_ack(1'b1);
      `CHK(d[`ST_SLEEP_ACKNOWLEDGE], 1'b1)
      wr(`OFS_TXDATA, 32'h0000_005a);
      wr(`OFS_CMD, 32'h0000_0008);
      rd(`OFS_RECEIVE_FOREGROUND_BUFFER);
      `CHK(d, 32'h0)
      wr(`OFS_CTRL, 32'h10);
      n = 0;
      for (h = 0; h < 3000 && engine_enable !== 1'b1; h = h + 1) begin
        @(posedge clk);
        if (sample_tick === 1'b1) n = n + 1;
      end
      `CHK(n >= 10 && n <= 12, 1'b1)
      rd(`OFS_RECEIVE_FOREGROUND_BUFFER);
      `CHK(d, 32'h0000_005a)
    end
  endtask
  task t_frame;
    begin
      pulse_eof;
      count_high(3'h1, 2 * BIT_CYC);
      `CHK(h, 0)
      wr(`OFS_CTRL, 32'h18);
      pulse_eof;
      count_high(3'h1, 3 * BIT_CYC);
      `CHK(h, BIT_CYC)
    end
  endtask
  task t_wait;
    begin
      @(posedge clk);
      wait_mode <= 1'b1;
      engine_irq <= 1'b1;
      wait_for(3'h3, 10);
      `CHK(engine_enable, 1'b1)
      @(posedge clk);
      wait_mode <= 1'b0;
      engine_irq <= 1'b0;
    end
  endtask
  task t_softrst;
    begin
      @(posedge clk);
      engine_busy <= 1'b1;
      wr(`OFS_CTRL, 32'h16);
      wait_for(3'h4, 10);
      repeat (2) @(posedge clk);
      `CHK(engine_enable, 1'b0)
      @(posedge clk);
      engine_busy <= 1'b0;
      go_normal(32'h14);
    end
  endtask
  // glitch filter on: a short dominant run must not wake
  task t_filter;
    begin
      wr(`OFS_CTRL, 32'h15);
      poll_ack(1'b1);
      rx_dom <= 1'b1;
      repeat (30) @(posedge clk);
      rx_dom <= 1'b0;
      rd(`OFS_STATUS);
      `CHK(d[`ST_SLEEP_ACKNOWLEDGE], 1'b1)
      rx_dom <= 1'b1;
      repeat (80) @(posedge clk);
      rx_dom <= 1'b0;
      rd(`OFS_STATUS);
      `CHK(d[`ST_SLEEP_ACKNOWLEDGE], 1'b0)
    end
  endtask
  task t_pdown;
    begin
      poll_ack(1'b1);
      `CHK(d[`ST_SLEEP_ACKNOWLEDGE], 1'b1)
      @(posedge clk);
      engine_busy <= 1'b1;
      stop_mode <= 1'b1;
      wait_for(3'h4, 10);
      rd(`OFS_CTRL);
      `CHK({r, d}, {`AXI_SLVERR, 32'h0})
      wr(`OFS_CTRL, 32'h0);
      `CHK(r, `AXI_SLVERR)
      rx_dom <= 1'b1;
      wait_for(3'h2, 20);
      `CHK(can_transmit_pin, 1'b1)
      `CHK(engine_enable, 1'b0)
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_timing;
    t_sleep;
    t_frame;
    t_wait;
    t_softrst;
    t_filter;
    t_pdown;
    give_verdict;
  end
endmodule

bind can_power_timing can_pm_props #(.DATA_W(DATA_W)) u_props (.*);
